// file: design/cond_cmd_ctrl.v
`include "cond_cmd_defs.vh"
module cond_cmd_ctrl #(
    parameter CHECK_COUNT = 12,
    parameter MEM_WORDS = 64
) (
    // Clock and reset
    input wire CLOCK,
    input wire RESET,
    input wire CHIP_CLEAR_N,
    // Serial link
    input wire LINK_SCLK,
    input wire LINK_SEL_N,
    input wire LINK_MOSI,
    // Check results from analog monitors
    input wire [CHECK_COUNT-1:0] CHECK_FAULT,
    // Converter data
    input wire [15:0] MEASURED_CODE,
    // Outputs
    output reg [1:0] MODE,
    output reg [15:0] DAC_CODE,
    output reg DAC_FORCED,
    output reg ADC_SELF_TEST,
    output reg [4:0] ADC_PSEUDO_SEL,
    output reg [2:0] SLOT_MEASURE,
    output reg SLOT_STROBE,
    output reg [15:0] CHECK_STATUS,
    output reg MEMORY_ERROR,
    output reg [15:0] READ_DATA
);
    localparam MODE_COMMAND = 2'h0;
    localparam MODE_SLEEP = 2'h1;
    localparam MODE_CYCLIC = 2'h2;
    localparam SLOT_BRIDGE = 3'h0;
    localparam SLOT_TEMP = 3'h1;
    localparam SLOT_BZERO = 3'h2;
    localparam SLOT_TZERO = 3'h3;
    localparam SLOT_CHECK = 3'h4;

    function [15:0] crc_step;
        input [15:0] crc;
        input [15:0] word;
        integer i;
        reg [15:0] c;
        begin
            c = crc ^ word;
            for (i = 0; i < 16; i = i + 1) begin
                if (c[15])
                    c = {c[14:0], 1'b0} ^ 16'h1021;
                else
                    c = {c[14:0], 1'b0};
            end
            crc_step = c;
        end
    endfunction

    // ===================================================
    // Clear pin synchroniser, drives a separate synchronous soft reset
    reg [1:0] clear_sync;
    always @(posedge CLOCK or posedge RESET) begin
        if (RESET)
            clear_sync <= 2'h0;
        else
            clear_sync <= {clear_sync[0], CHIP_CLEAR_N};
    end
    wire soft_reset = !clear_sync[1];

    // ===================================================
    // Frame receiver
    wire frame_valid;
    wire [7:0] frame_cmd;
    wire [15:0] frame_data;
    link_sampler receiver (
        .clock(CLOCK),
        .reset(RESET),
        .sclk_pin(LINK_SCLK),
        .sel_n_pin(LINK_SEL_N),
        .data_pin(LINK_MOSI),
        .frame_valid(frame_valid),
        .frame_cmd(frame_cmd),
        .frame_data(frame_data)
    );

    // ===================================================
    // Memory, CRC walker and command decode
    reg [15:0] mem [0:MEM_WORDS-1];
    reg crc_busy;
    reg [5:0] crc_addr;
    reg [15:0] crc_acc;
    reg crc_checked;
    reg [2:0] slot;
    wire [15:0] cyc = mem[`ADDR_CYCLIC_CONFIG];
    wire [15:0] sel = mem[`ADDR_CHECK_SELECT];
    wire is_write = frame_cmd[7:6] == 2'h1;
    wire is_read = frame_cmd[7:6] == 2'h0 && frame_cmd != `CMD_WRITE_CRC;
    integer k;

    always @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            for (k = 0; k < MEM_WORDS; k = k + 1)
                mem[k] <= `RESET_WORD;
        end else if (frame_valid && is_write && !crc_busy) begin
            mem[frame_cmd[5:0]] <= frame_data;
        end else if (crc_busy && crc_checked && crc_addr == `ADDR_CHECKSUM) begin
            // Only a requested CRC write stores; the start-up walk only compares
            mem[`ADDR_CHECKSUM] <= crc_acc;
        end
    end

    always @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            crc_busy <= 1'b0;
            crc_addr <= 6'h00;
            crc_acc <= `CRC_SEED;
            crc_checked <= 1'b0;
            MEMORY_ERROR <= 1'b1;
        end else if (soft_reset) begin
            crc_busy <= 1'b0;
            crc_addr <= 6'h00;
            crc_acc <= `CRC_SEED;
            crc_checked <= 1'b0;
        end else if (crc_busy) begin
            if (crc_addr == `ADDR_CHECKSUM) begin
                crc_busy <= 1'b0;
                if (!crc_checked)
                    MEMORY_ERROR <= crc_acc != mem[`ADDR_CHECKSUM];
                crc_checked <= 1'b1;
            end else begin
                crc_acc <= crc_step(crc_acc, mem[crc_addr]);
                crc_addr <= crc_addr + 6'h01;
            end
        end else if (!crc_checked) begin
            crc_busy <= 1'b1;
        end else if (frame_valid && frame_cmd == `CMD_WRITE_CRC) begin
            crc_busy <= 1'b1;
            crc_addr <= 6'h00;
            crc_acc <= `CRC_SEED;
        end
    end

    // ===================================================
    // Mode, diagnostics, checks and read-back
    always @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            MODE <= MODE_COMMAND;
            DAC_CODE <= 16'h0000;
            DAC_FORCED <= 1'b0;
            ADC_SELF_TEST <= 1'b0;
            ADC_PSEUDO_SEL <= 5'h00;
            CHECK_STATUS <= 16'h0000;
            READ_DATA <= 16'h0000;
        end else if (soft_reset) begin
            MODE <= MODE_COMMAND;
            DAC_FORCED <= 1'b0;
            ADC_SELF_TEST <= 1'b0;
            CHECK_STATUS <= 16'h0000;
        end else if (frame_valid) begin
            case (frame_cmd)
                `CMD_COMMAND_MODE: MODE <= MODE_COMMAND;
                `CMD_SLEEP_MODE: MODE <= MODE_SLEEP;
                `CMD_CYCLIC_MODE: MODE <= MODE_CYCLIC;
                `CMD_CHECK_B0, `CMD_CHECK_B2: begin
                    CHECK_STATUS <= {{(16-CHECK_COUNT){1'b0}},
                        CHECK_FAULT & sel[CHECK_COUNT-1:0]};
                end
                `CMD_DAC_DIAG: begin
                    DAC_CODE <= frame_data;
                    DAC_FORCED <= 1'b1;
                end
                `CMD_ADC_DIAG: begin
                    ADC_SELF_TEST <= 1'b1;
                    ADC_PSEUDO_SEL <= frame_data[4:0];
                end
                `CMD_NORMAL_OUT: begin
                    DAC_FORCED <= 1'b0;
                    ADC_SELF_TEST <= 1'b0;
                end
                default: begin
                    if (is_read)
                        READ_DATA <= mem[frame_cmd[5:0]];
                end
            endcase
        end else if (!DAC_FORCED) begin
            DAC_CODE <= MEASURED_CODE;
        end
    end

    // ===================================================
    // Cyclic slot scheduler
    function slot_enabled;
        input [2:0] s;
        input [15:0] cfg;
        begin
            case (s)
                SLOT_BRIDGE: slot_enabled = cfg[`CYC_BRIDGE_EN];
                SLOT_TEMP: slot_enabled = cfg[`CYC_TEMP_EN];
                SLOT_BZERO: slot_enabled = cfg[`CYC_BZERO_EN];
                SLOT_TZERO: slot_enabled = cfg[`CYC_TZERO_EN];
                SLOT_CHECK: slot_enabled = cfg[`CYC_CHECK_EN];
                default: slot_enabled = 1'b0;
            endcase
        end
    endfunction

    always @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            slot <= SLOT_BRIDGE;
            SLOT_MEASURE <= SLOT_BRIDGE;
            SLOT_STROBE <= 1'b0;
        end else begin
            SLOT_STROBE <= 1'b0;
            if (MODE != MODE_CYCLIC || soft_reset) begin
                slot <= SLOT_BRIDGE;
            end else begin
                slot <= (slot == SLOT_CHECK) ? SLOT_BRIDGE : slot + 3'h1;
                if (slot_enabled(slot, cyc)) begin
                    SLOT_MEASURE <= slot;
                    SLOT_STROBE <= 1'b1;
                end
            end
        end
    end
endmodule

// file: design/cond_cmd_defs.vh
`ifndef COND_CMD_DEFS_VH
`define COND_CMD_DEFS_VH
// Command codes
`define CMD_COMMAND_MODE 8'ha9
`define CMD_SLEEP_MODE 8'ha8
`define CMD_CYCLIC_MODE 8'hab
`define CMD_WRITE_CRC 8'h39
`define CMD_CHECK_B0 8'hb0
`define CMD_CHECK_B2 8'hb2
`define CMD_DAC_DIAG 8'hd0
`define CMD_ADC_DIAG 8'hd1
`define CMD_NORMAL_OUT 8'hd2
`define CMD_MEM_WRITE_BASE 8'h40
`define CMD_MEM_READ_BASE 8'h00
// Memory word offsets
`define ADDR_CYCLIC_CONFIG 6'h1e
`define ADDR_CHECK_SELECT 6'h21
`define ADDR_CHECKSUM 6'h35
// Cyclic config fields
`define CYC_BRIDGE_EN 0
`define CYC_TEMP_EN 1
`define CYC_CHECK_EN 2
`define CYC_BZERO_EN 3
`define CYC_TZERO_EN 4
// Reset values
`define RESET_WORD 16'h0000
`define CRC_SEED 16'hffff
// Serial frame: 8 command bits and 16 data bits
`define FRAME_BITS 24
`endif

// file: design/link_sampler.v
`include "cond_cmd_defs.vh"
module link_sampler (
    // Clock and reset
    input wire clock,
    input wire reset,
    // Pins
    input wire sclk_pin,
    input wire sel_n_pin,
    input wire data_pin,
    // Received frame
    output reg frame_valid,
    output reg [7:0] frame_cmd,
    output reg [15:0] frame_data
);
    // ===================================================
    // Synchronisers
    reg [1:0] clk_sync;
    reg [1:0] sel_sync;
    reg [1:0] dat_sync;
    reg clk_last;
    reg sel_last;
    reg [23:0] shift;
    reg [4:0] count;
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            clk_sync <= 2'h0;
            sel_sync <= 2'h3;
            dat_sync <= 2'h0;
            clk_last <= 1'b0;
            sel_last <= 1'b1;
        end else begin
            clk_sync <= {clk_sync[0], sclk_pin};
            sel_sync <= {sel_sync[0], sel_n_pin};
            dat_sync <= {dat_sync[0], data_pin};
            clk_last <= clk_sync[1];
            sel_last <= sel_sync[1];
        end
    end
    // ===================================================
    // Shift on rising link clock, frame ends on select release
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            shift <= 24'h000000;
            count <= 5'h00;
            frame_valid <= 1'b0;
            frame_cmd <= 8'h00;
            frame_data <= 16'h0000;
        end else begin
            frame_valid <= 1'b0;
            if (sel_sync[1]) begin
                count <= 5'h00;
                if (!sel_last && count == 5'd8) begin
                    frame_valid <= 1'b1;
                    frame_cmd <= shift[7:0];
                    frame_data <= 16'h0000;
                end else if (!sel_last && count == 5'd24) begin
                    frame_valid <= 1'b1;
                    frame_cmd <= shift[23:16];
                    frame_data <= shift[15:0];
                end
            end else if (clk_sync[1] && !clk_last && count != 5'd25) begin
                // Count saturates past 24 so that longer frames are refused
                if (count != 5'd24)
                    shift <= {shift[22:0], dat_sync[1]};
                count <= count + 5'h01;
            end
        end
    end
endmodule

// file: dv/host_link_model.sv
// ==========
// Host side of the serial link
module host_link_model (
    // Link pins
    output logic sclk,
    output logic sel_n,
    output logic mosi,
    // Chip clear pin
    output logic clear_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk = 0;
        sel_n = 1;
        mosi = 0;
        clear_n = 1;
    end
    // Clock stands still outside frames
    task automatic send(input logic [7:0] c, input logic [15:0] d, input int n);
        logic [23:0] f = {c, d};
        sel_n = 0;
        #320;
        for (int i = 0; i < n; i++) begin
            mosi = f[23 - i];
            #160 sclk = 1;
            #160 sclk = 0;
        end
        #160 sel_n = 1;
        mosi = ~mosi;
    endtask
    task automatic clear_pulse;
        clear_n = 0;
        #400 clear_n = 1;
    endtask
endmodule

// file: dv/cond_cmd_ctrl_chk.sv
// ==========
// Port checker
module cond_cmd_ctrl_chk #(
    parameter CHECK_COUNT = 12
) (
    // Clock and reset
    input wire CLOCK,
    input wire RESET,
    input wire CHIP_CLEAR_N,
    // Watched ports
    input wire LINK_SEL_N,
    input wire [1:0] MODE,
    input wire [15:0] DAC_CODE,
    input wire DAC_FORCED,
    input wire ADC_SELF_TEST,
    input wire [2:0] SLOT_MEASURE,
    input wire SLOT_STROBE,
    input wire [15:0] CHECK_STATUS,
    input wire [15:0] READ_DATA
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    wire idle = LINK_SEL_N && CHIP_CLEAR_N;
    mode_legal_a: assert property (MODE != 2'h3)
        else $error("mode code out of range");
    strobe_mode_a: assert property (SLOT_STROBE |-> MODE == 2'h2 || $past(MODE) == 2'h2)
        else $error("slot strobe outside cyclic mode");
    slot_code_a: assert property (SLOT_STROBE |-> SLOT_MEASURE <= 3'h4)
        else $error("slot code out of range");
    slot_order_a: assert property (SLOT_STROBE && $past(SLOT_STROBE) |->
        SLOT_MEASURE == (($past(SLOT_MEASURE) == 3'h4) ? 3'h0 : $past(SLOT_MEASURE) + 3'h1))
        else $error("slot order broken");
    dac_hold_a: assert property ((idle && DAC_FORCED) [*8] |-> $stable(DAC_CODE))
        else $error("forced dac code moved");
    clear_mode_a: assert property (!CHIP_CLEAR_N [*5] |->
        MODE == 2'h0 && !DAC_FORCED && !ADC_SELF_TEST)
        else $error("chip clear ignored");
    status_mask_a: assert property ((CHECK_STATUS >> CHECK_COUNT) == 16'h0)
        else $error("status bit beyond check count");
    idle_mode_a: assert property (idle [*8] |->
        $stable(MODE) && $stable(DAC_FORCED) && $stable(ADC_SELF_TEST))
        else $error("mode moved without a frame");
    idle_data_a: assert property (idle [*8] |->
        $stable(READ_DATA) && $stable(CHECK_STATUS))
        else $error("data moved without a frame");
    cover property (MODE == 2'h2 && SLOT_STROBE);
    cover property ($rose(DAC_FORCED));
    cover property ($rose(ADC_SELF_TEST));
endmodule

// file: dv/cond_cmd_ctrl_tb.sv
module cond_cmd_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0;
    logic reset = 1;
    logic [11:0] fault = 12'h0;
    logic [15:0] meas = 16'h0;
    wire sclk, sel_n, mosi, clear_n, dac_forced, adc_st, strobe, mem_err;
    wire [1:0] mode;
    wire [2:0] slot;
    wire [4:0] adc_sel;
    wire [15:0] dac_code, status, read_data;
    int err_count = 0;
    int n_compared = 0;
    int seed = 10559;
    int sel_q[$];
    logic [15:0] exp_q[$];
    logic [15:0] w;
    logic [15:0] snap = 16'h0;
    int n_strobe = 0;
    int s0;
    logic [7:0] mc[4] = '{8'hab, 8'ha8, 8'hc5, 8'ha9};
    logic [15:0] mv[4] = '{16'h2, 16'h1, 16'h1, 16'h0};
    string nm[8] = '{"mode", "dac_code", "adc_diag", "status", "mem_err", "read", "forced",
        "strobes"};
    host_link_model i_host (.sclk(sclk), .sel_n(sel_n), .mosi(mosi), .clear_n(clear_n));
    cond_cmd_ctrl i_dut (.CLOCK(clock), .RESET(reset), .CHIP_CLEAR_N(clear_n),
        .LINK_SCLK(sclk), .LINK_SEL_N(sel_n), .LINK_MOSI(mosi), .CHECK_FAULT(fault),
        .MEASURED_CODE(meas), .MODE(mode), .DAC_CODE(dac_code), .DAC_FORCED(dac_forced),
        .ADC_SELF_TEST(adc_st), .ADC_PSEUDO_SEL(adc_sel), .SLOT_MEASURE(slot),
        .SLOT_STROBE(strobe), .CHECK_STATUS(status), .MEMORY_ERROR(mem_err),
        .READ_DATA(read_data));
    initial forever #20 clock = ~clock;
    function automatic logic [15:0] obs(input int s);
        case (s)
            0: return {14'h0, mode};
            1: return dac_code;
            2: return {10'h0, adc_st, adc_sel};
            3: return status;
            4: return {15'h0, mem_err};
            5: return read_data;
            7: return snap;
            default: return {15'h0, dac_forced};
        endcase
    endfunction
    always @(posedge clock) begin
        if (strobe === 1'b1)
            n_strobe++;
    end
    task automatic count_strobes;
        s0 = n_strobe;
        repeat (10) @(posedge clock);
        #1 snap = 16'(n_strobe - s0);
    endtask
    task automatic note(input int s, input logic [15:0] v);
        sel_q.push_back(s);
        exp_q.push_back(v);
    endtask
    // ==========
    // Scoreboard
    always @(posedge clock) begin
        if (sel_q.size() > 0) begin
            n_compared++;
            if (obs(sel_q[0]) !== exp_q[0]) begin
                err_count++;
                $display("CHECK FAILED %s expected %h seen %h", nm[sel_q[0]], exp_q[0],
                    obs(sel_q[0]));
            end
            void'(sel_q.pop_front());
            void'(exp_q.pop_front());
        end
    end
    task automatic cmd(input logic [7:0] c, input logic [15:0] d, input int n);
        @(posedge clock);
        #1 i_host.send(c, d, n);
        repeat (12) @(posedge clock);
        #1;
    endtask
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #1000000 err_count++;
        complete_run();
    end
    // ==========
    // Tests
    initial begin
        repeat (16) @(posedge clock);
        #1 reset = 0;
        repeat (80) @(posedge clock);
        note(4, 16'h1);
        #1 i_host.clear_pulse();
        repeat (80) @(posedge clock);
        note(4, 16'h1);
        for (int i = 0; i < 4; i++) begin
            cmd(mc[i], 16'h0, 8);
            note(0, mv[i]);
        end
        cmd(8'ha8, 16'h0, 16);
        note(0, 16'h0);
        $display("test modes done");
        w = $random(seed);
        cmd(8'h61, w, 24);
        cmd(8'h21, 16'h0, 8);
        note(5, w);
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            #1 fault = $random(seed);
            cmd(i ? 8'hb0 : 8'hb2, 16'h0, 8);
            note(3, {4'h0, fault & w[11:0]});
        end
        $display("test checks done");
        cmd(8'h5e, 16'h001f, 24);
        cmd(8'hab, 16'h0, 8);
        note(0, 16'h2);
        count_strobes();
        note(7, 16'd10);
        cmd(8'h5e, 16'h0001, 24);
        count_strobes();
        note(7, 16'd2);
        $display("test cyclic done");
        w = $random(seed);
        cmd(8'hd0, w, 24);
        meas = ~w;
        repeat (12) @(posedge clock);
        note(1, w);
        note(6, 16'h1);
        cmd(8'hd2, 16'h0, 24);
        note(6, 16'h0);
        note(1, meas);
        cmd(8'hd1, 16'h001f, 24);
        note(2, 16'h003f);
        $display("test diagnostics done");
        cmd(8'h39, 16'h0, 8);
        repeat (80) @(posedge clock);
        #1 i_host.clear_pulse();
        repeat (80) @(posedge clock);
        note(4, 16'h0);
        note(0, 16'h0);
        note(2, 16'h001f);
        repeat (10) @(posedge clock);
        $display("test checksum done");
        complete_run();
    end
endmodule
bind cond_cmd_ctrl cond_cmd_ctrl_chk #(.CHECK_COUNT(CHECK_COUNT)) i_chk (
    .CLOCK(CLOCK), .RESET(RESET), .CHIP_CLEAR_N(CHIP_CLEAR_N), .LINK_SEL_N(LINK_SEL_N),
    .MODE(MODE), .DAC_CODE(DAC_CODE), .DAC_FORCED(DAC_FORCED), .ADC_SELF_TEST(ADC_SELF_TEST),
    .SLOT_MEASURE(SLOT_MEASURE), .SLOT_STROBE(SLOT_STROBE), .CHECK_STATUS(CHECK_STATUS),
    .READ_DATA(READ_DATA));
